// ### dv/cbu_branch_unit_properties.sv
// concurrent checks on the branch unit ports
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit_properties #(
    parameter int PC_W = 16,
    parameter int OFFSET_W = 7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire cbu_pkg::cbu_branch_type instr_kind,
    input wire logic [2:0] flag_sel,
    input wire logic [OFFSET_W-1:0] offset_k,
    input wire logic [7:0] processor_flags_register,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic busy,
    input wire logic done,
    input wire logic taken,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_next
);
    import cbu_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // request seen while idle
    sequence s_accept;
        instr_valid && !busy;
    endsequence
    // closing cycle of a taken branch
    sequence s_taken_end;
        !busy && done && taken && pc_load;
    endsequence
    chk_accept_answers: assert property (s_accept |=> busy || done)
        else $error("accepted request got no answer");
    chk_taken_sequence: assert property (busy |=> s_taken_end)
        else $error("taken branch did not close after one wait");
    chk_taken_after_busy: assert property (taken |-> $past(busy))
        else $error("taken without a wait cycle");
    chk_done_loads_pc: assert property ((done || pc_load) |-> (done && pc_load))
        else $error("done and pc load apart");
    chk_busy_cause: assert property ($rose(busy) |-> $past(instr_valid))
        else $error("busy without a request");
    chk_advance_pc: assert property (done && !taken |->
        $past(instr_valid) && !$past(busy) && pc_next == $past(pc_in) + 1'b1)
        else $error("fall-through pc wrong");
    chk_taken_target: assert property (taken |->
        pc_next == $past(pc_in, 2) + PC_W'($signed($past(offset_k, 2))) + 1'b1)
        else $error("branch target wrong");
    // the edge after a reset sees the cleared value, so skip that one
    chk_pc_holds: assert property (!pc_load && !$past(reset) |-> $stable(pc_next))
        else $error("pc value moved without a load");
endmodule : cbu_branch_unit_properties
bind cbu_branch_unit cbu_branch_unit_properties #(.PC_W(PC_W), .OFFSET_W(OFFSET_W)) props (
    .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_kind(instr_kind),
    .flag_sel(flag_sel), .offset_k(offset_k), .processor_flags_register(processor_flags_register),
    .pc_in(pc_in), .busy(busy), .done(done), .taken(taken), .pc_load(pc_load), .pc_next(pc_next));
`default_nettype wire

// ### dv/cbu_branch_unit_tb.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/1ps
`default_nettype none
`include "cbu_regs.svh"
module cbu_branch_unit_tb;
    import cbu_pkg::*;
    logic clk = 0, reset = 1, valid = 0, busy, done, taken, pc_load;
    cbu_branch_type kind = branch_equal;
    logic [2:0] sel = 0;
    logic [6:0] off = 0;
    logic [7:0] flags = 0; // flag bits C0 Z1 N2 V3 S4 H5 T6 I7
    logic [15:0] pc, pc_next;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    always #5 clk = ~clk;
    cbu_branch_unit dut (.clk(clk), .reset(reset), .instr_valid(valid), .instr_kind(kind),
        .flag_sel(sel), .offset_k(off), .processor_flags_register(flags), .pc_in(pc),
        .busy(busy), .done(done), .taken(taken), .pc_load(pc_load), .pc_next(pc_next));
    cbu_core_model model (.clk(clk), .reset(reset), .pc_load(pc_load), .pc_next(pc_next), .pc(pc));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    // expected condition; index picks the flag, low kind bit the sense, flipped for the unsigned and signed pairs
    function automatic logic cond(input cbu_branch_type kd, input logic [7:0] f);
        logic [9:0] v;
        v = {f[7], f[3], f[6], f[5], f[2] ^ f[3], f[2], f[0], f[0], f[1], 1'b0};
        return v[kd[4:1]] ^ kd[0] ^ (kd[4:1] == 4'h3 || kd[4:1] == 4'h5);
    endfunction : cond
    // one request; judge the verdict, cycle count and new pc
    task automatic issue(input cbu_branch_type kd, input logic [2:0] s, input logic [7:0] f,
            input logic [6:0] k, input logic exp);
        logic [15:0] p;
        int n;
        kind = kd;
        sel = s;
        flags = f;
        off = k;
        p = pc;
        valid = 1;
        n = 0;
        @(posedge clk);
        #1 valid = 0;
        check(busy, exp);
        while (done !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1 n++;
        end
        check(taken, exp);
        check(pc_load, 1'b1);
        check(16'(n), 16'(exp ? `CBU_TAKEN_CYCLES - 1 : `CBU_NOT_TAKEN_CYCLES - 1));
        check(pc_next, p + (exp ? {{9{k[6]}}, k} : 16'h0000) + 16'h0001);
    endtask : issue
    task automatic t_generic;
        for (int s = 0; s < 8; s++) begin
            issue(branch_on_flag_set, 3'(s), 8'h01 << s, 7'h05, 1'b1);
            issue(branch_on_flag_set, 3'(s), ~(8'h01 << s), 7'h05, 1'b0);
            issue(branch_on_flag_clear, 3'(s), 8'h01 << s, 7'h7B, 1'b0);
            issue(branch_on_flag_clear, 3'(s), ~(8'h01 << s), 7'h7B, 1'b1);
        end
        $display("generic done");
    endtask : t_generic
    // every named branch against lone flags, none and all; spare codes never branch
    task automatic t_named;
        cbu_branch_type kd;
        logic [7:0] f;
        logic e;
        for (int i = 2; i < 32; i++) begin
            kd = cbu_branch_type'(i);
            for (int j = 0; j < 10; j++) begin
                f = (j == 9) ? 8'hFF : 8'(16'h0001 << j);
                e = (i < 20) && cond(kd, f);
                issue(kd, 3'h0, f, 7'h02, e);
            end
        end
        $display("named done");
    endtask : t_named
    // offset extremes
    task automatic t_offset;
        logic [6:0] ks [4] = '{7'h40, 7'h3F, 7'h7F, 7'h00};
        foreach (ks[i]) issue(branch_irq_disabled, 3'h0, 8'h00, ks[i], 1'b1);
        $display("offset done");
    endtask : t_offset
    // request held during the wait must not be queued
    task automatic t_refuse;
        kind = branch_irq_enabled;
        flags = 8'h80;
        valid = 1;
        repeat (2) @(posedge clk);
        #1 valid = 0;
        check(done & taken, 1'b1);
        @(posedge clk);
        #1 check(done, 1'b0);
        check(busy, 1'b0);
        $display("refuse done");
    endtask : t_refuse
    // reset in the middle of a taken branch drops the pending load
    task automatic t_reset;
        kind = branch_irq_disabled;
        flags = 8'h00;
        valid = 1;
        @(posedge clk);
        #1 valid = 0;
        reset = 1;
        @(posedge clk);
        #1 reset = 0;
        check({busy, done, taken, pc_load}, 4'h0);
        check(pc_next, 16'h0000);
        issue(branch_equal, 3'h0, 8'h02, 7'h03, 1'b1);
        $display("reset done");
    endtask : t_reset
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 reset = 0;
        check({busy, done, taken, pc_load}, 4'h0);
        check(pc_next, 16'h0000);
        t_generic();
        t_named();
        t_offset();
        t_refuse();
        t_reset();
        summarize();
    end
endmodule : cbu_branch_unit_tb
`default_nettype wire

// ### dv/cbu_core_model.sv
// core-side stand-in: holds the program counter and follows every pc load
`timescale 1ns/1ps
`default_nettype none
module cbu_core_model #(
    parameter logic [15:0] PC_START = 16'hFFC0 // near the top, so targets wrap
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pc_load,
    input wire logic [15:0] pc_next,
    output logic [15:0] pc
);
    // pc moves only on reset or a load; flags live in the bench and this model never writes them
    always_ff @(posedge clk) begin
        if (reset) begin
            pc <= PC_START;
        end else if (pc_load) begin
            pc <= pc_next;
        end
    end
endmodule : cbu_core_model
`default_nettype wire

// ### src/cbu_branch_unit.sv
// conditional relative branch sequencer: decides, computes target, loads pc
`timescale 1ns/1ps
`default_nettype none
`include "cbu_regs.svh"
module cbu_branch_unit #(
    parameter int PC_W = `CBU_PC_W, // program counter width
    parameter int OFFSET_W = `CBU_OFFSET_W // width of signed offset k
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire cbu_pkg::cbu_branch_type instr_kind,
    input wire logic [`CBU_SEL_W-1:0] flag_sel,
    input wire logic [OFFSET_W-1:0] offset_k,
    input wire logic [`CBU_FLAGS_W-1:0] processor_flags_register,
    input wire logic [PC_W-1:0] pc_in,
    output logic busy,
    output logic done,
    output logic taken,
    output logic pc_load,
    output logic [PC_W-1:0] pc_next
);
    import cbu_pkg::*;

    cbu_cond_if cif (); // link to the evaluator

    // evaluator sees the live request; flags are only read, never driven
    assign cif.kind = instr_kind;
    assign cif.sel = flag_sel;
    assign cif.flags = processor_flags_register;

    cbu_cond_eval u_eval (
        .c(cif)
    );

    cbu_state_type state; // sequencer state
    cbu_state_type next_state;
    logic [PC_W-1:0] target; // held branch target
    logic [PC_W-1:0] next_target;
    logic next_busy;
    logic next_done;
    logic next_taken;
    logic next_pc_load;
    logic [PC_W-1:0] next_pc_next;
    logic [PC_W-1:0] k_ext; // sign-extended offset
    logic [PC_W-1:0] one_pc; // constant one at pc width

    // sign extension keeps backward branches correct
    assign k_ext = {{(PC_W-OFFSET_W){offset_k[OFFSET_W-1]}}, offset_k};
    assign one_pc = {{(PC_W-1){1'b0}}, 1'b1};

    // next-state and output computation
    always_comb begin
        next_state = state;
        next_target = target;
        next_busy = 1'b0;
        next_done = 1'b0;
        next_taken = 1'b0;
        next_pc_load = 1'b0;
        next_pc_next = pc_next;
        case (state)
            cbu_idle: begin
                if (instr_valid && cif.cond) begin
                    // taken: hold target for the second cycle
                    next_target = pc_in + k_ext + one_pc;
                    next_busy = 1'b1;
                    next_state = cbu_taken_wait;
                end else if (instr_valid) begin
                    // not taken: fall through in one cycle
                    next_done = 1'b1;
                    next_pc_load = 1'b1;
                    next_pc_next = pc_in + one_pc;
                end
            end
            cbu_taken_wait: begin
                // second cycle: new requests here are ignored
                next_done = 1'b1;
                next_taken = 1'b1;
                next_pc_load = 1'b1;
                next_pc_next = target;
                next_state = cbu_idle;
            end
            default: begin
                next_state = cbu_idle;
            end
        endcase
    end

    // registers only; synchronous reset
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= cbu_idle;
            target <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            taken <= 1'b0;
            pc_load <= 1'b0;
            pc_next <= '0;
        end else begin
            state <= next_state;
            target <= next_target;
            busy <= next_busy;
            done <= next_done;
            taken <= next_taken;
            pc_load <= next_pc_load;
            pc_next <= next_pc_next;
        end
    end
endmodule : cbu_branch_unit
`default_nettype wire

// ### src/cbu_cond_eval.sv
// combinational condition evaluator for the conditional branches
`timescale 1ns/1ps
`default_nettype none
`include "cbu_regs.svh"
module cbu_cond_eval (
    cbu_cond_if.eval c
);
    import cbu_pkg::*;

    // pick the flag and the level that makes the branch taken
    always_comb begin
        logic bit_val;
        logic want;
        bit_val = c.flags[c.sel];
        want = 1'b1;
        case (c.kind)
            branch_on_flag_set: begin
                bit_val = c.flags[c.sel];
                want = 1'b1;
            end
            branch_on_flag_clear: begin
                bit_val = c.flags[c.sel];
                want = 1'b0;
            end
            branch_equal, branch_not_equal: begin
                bit_val = c.flags[`CBU_FLAG_ZERO];
                want = (c.kind == branch_equal);
            end
            branch_carry_one, branch_carry_zero: begin
                bit_val = c.flags[`CBU_FLAG_CARRY];
                want = (c.kind == branch_carry_one);
            end
            branch_unsigned_ge, branch_unsigned_lt: begin
                // same test as the carry pair, kept as aliases
                bit_val = c.flags[`CBU_FLAG_CARRY];
                want = (c.kind == branch_unsigned_lt);
            end
            branch_negative, branch_positive: begin
                bit_val = c.flags[`CBU_FLAG_NEG];
                want = (c.kind == branch_negative);
            end
            branch_signed_ge, branch_signed_lt: begin
                // computed from n and v, not the stored sign bit
                bit_val = c.flags[`CBU_FLAG_NEG] ^ c.flags[`CBU_FLAG_OVF];
                want = (c.kind == branch_signed_lt);
            end
            branch_half_carry_one, branch_half_carry_zero: begin
                bit_val = c.flags[`CBU_FLAG_HALF];
                want = (c.kind == branch_half_carry_one);
            end
            branch_copy_bit_one, branch_copy_bit_zero: begin
                bit_val = c.flags[`CBU_FLAG_COPY];
                want = (c.kind == branch_copy_bit_one);
            end
            branch_overflow_one, branch_overflow_zero: begin
                bit_val = c.flags[`CBU_FLAG_OVF];
                want = (c.kind == branch_overflow_one);
            end
            branch_irq_enabled: begin
                bit_val = c.flags[`CBU_FLAG_IRQ];
                want = 1'b1;
            end
            branch_irq_disabled: begin
                bit_val = c.flags[`CBU_FLAG_IRQ];
                want = 1'b0;
            end
            default: begin
                // unused encodings never branch
                bit_val = 1'b0;
                want = 1'b1;
            end
        endcase
        c.cond = (bit_val == want);
    end
endmodule : cbu_cond_eval
`default_nettype wire

// ### src/cbu_cond_if.sv
// carrier between the sequencer and the condition evaluator
`timescale 1ns/1ps
`default_nettype none
`include "cbu_regs.svh"
interface cbu_cond_if;
    cbu_pkg::cbu_branch_type kind; // instruction being evaluated
    logic [`CBU_SEL_W-1:0] sel; // generic flag selector
    logic [`CBU_FLAGS_W-1:0] flags; // processor_flags_register snapshot
    logic cond; // condition holds
    modport seq (output kind, output sel, output flags, input cond);
    modport eval (input kind, input sel, input flags, output cond);
endinterface : cbu_cond_if
`default_nettype wire

// ### src/cbu_pkg.sv
// types shared by the conditional branch unit modules
package cbu_pkg;
    // one entry per conditional branch instruction
    typedef enum logic [4:0] {
        branch_on_flag_set,
        branch_on_flag_clear,
        branch_equal,
        branch_not_equal,
        branch_carry_one,
        branch_carry_zero,
        branch_unsigned_ge,
        branch_unsigned_lt,
        branch_negative,
        branch_positive,
        branch_signed_ge,
        branch_signed_lt,
        branch_half_carry_one,
        branch_half_carry_zero,
        branch_copy_bit_one,
        branch_copy_bit_zero,
        branch_overflow_one,
        branch_overflow_zero,
        branch_irq_enabled,
        branch_irq_disabled
    } cbu_branch_type;
    // sequencer states
    typedef enum logic [0:0] {
        cbu_idle,
        cbu_taken_wait
    } cbu_state_type;
endpackage : cbu_pkg

// ### src/cbu_regs.svh
// constants for the conditional branch unit: flag positions, widths, cycle counts
// Overview of operation
// - flag-set branch takes when selected bit is 1
// - flag-clear branch takes when selected bit is 0
// - taken branch loads pc plus k plus one
// - flags untouched; one or two cycles
// - equal on zero 1, not-equal on zero 0
// - carry-one on carry 1, carry-zero on 0
// - unsigned ge on carry 0, lt on 1
// - negative on n 1, positive on n 0
// - signed ge when n xor v is 0
// - half-carry branches test half-carry flag
// - copy-bit branches test copy-bit flag
// - overflow branches test overflow flag
// - irq-enabled branch takes on enable 1
// - irq-disabled branch takes on enable 0
`ifndef CBU_REGS_SVH
`define CBU_REGS_SVH
`define CBU_FLAG_CARRY 3'h0
`define CBU_FLAG_ZERO 3'h1
`define CBU_FLAG_NEG 3'h2
`define CBU_FLAG_OVF 3'h3
`define CBU_FLAG_SIGN 3'h4
`define CBU_FLAG_HALF 3'h5
`define CBU_FLAG_COPY 3'h6
`define CBU_FLAG_IRQ 3'h7
`define CBU_FLAGS_W 8
`define CBU_SEL_W 3
`define CBU_PC_W 16
`define CBU_OFFSET_W 7
`define CBU_NOT_TAKEN_CYCLES 1
`define CBU_TAKEN_CYCLES 2
`endif
